// [logic/odt_timer.sv]
// Purpose: On-delay count-down timer with scan-based input and output memory
// Assumes: scan_end and fb_exec are one-cycle strobes from the scan sequencer
// Notes:   Timer state is evaluated only on fb_exec; pins move only on scan_end
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "odt_cfg.svh"

// Contract
// - Decrement current value per tick while running
// - At zero, stop and assert output
// - Hold zero and output while run stays on
// - Run off loads preset, output off
// - Output follows current value equal zero; code keeps it off while idle, even at zero
// - Preset 0..65535 from constant or register
// - Four tick units: 1s,100ms,10ms,1ms
// - Unique ascending instance index, 200 or 100
// - Own free-running 16-bit reference tick counter
// - Early error one unit, lag one scan
// - Run input sampled only at scan end
// - Output pin updated only at scan end
// - Output pin lags memory under one scan
// - Overall error three scans late at most
// - No retention; restart from initial state
// - Preset change waits for run off; zero expires
module odt_timer #(
  parameter int unsigned  TICK_MS_CYCLES = `ODT_MS_CYCLES,
  parameter int unsigned  TIMER_INDEX    = 0,
  parameter bit           SMALL_VARIANT  = 1'b0,
  parameter logic [15:0]  PRESET_CONST   = 16'h0000
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        run_input_pin,
  input  wire logic        scan_end,
  input  wire logic        fb_exec,
  output logic             timer_out_pin,
  output logic [15:0]      current_value,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata
);

  // Instance index, clamped to the legal range of the variant
  localparam int unsigned MAX_IDX = SMALL_VARIANT ? `ODT_MAX_INDEX_SML : `ODT_MAX_INDEX;
  localparam logic [7:0]  IDX     = 8'((TIMER_INDEX > MAX_IDX) ? MAX_IDX : TIMER_INDEX);
  localparam logic        IDX_OK  = (TIMER_INDEX <= MAX_IDX);

  // ---------------- Tick dividers ----------------
  logic tick_1ms;
  logic tick_10ms;
  logic tick_100ms;
  logic tick_1s;

  odt_tick_div #(
    .W   (17),
    .DIV (17'(TICK_MS_CYCLES))
  ) u_div_ms (
    .clk     (clk),
    .sys_rst (sys_rst),
    .step_in (1'b1),
    .tick_q  (tick_1ms)
  );

  odt_tick_div #(
    .W   (4),
    .DIV (4'(`ODT_DECADE))
  ) u_div_10ms (
    .clk     (clk),
    .sys_rst (sys_rst),
    .step_in (tick_1ms),
    .tick_q  (tick_10ms)
  );

  odt_tick_div #(
    .W   (4),
    .DIV (4'(`ODT_DECADE))
  ) u_div_100ms (
    .clk     (clk),
    .sys_rst (sys_rst),
    .step_in (tick_10ms),
    .tick_q  (tick_100ms)
  );

  odt_tick_div #(
    .W   (4),
    .DIV (4'(`ODT_DECADE))
  ) u_div_1s (
    .clk     (clk),
    .sys_rst (sys_rst),
    .step_in (tick_100ms),
    .tick_q  (tick_1s)
  );

  // ---------------- Register file ----------------
  logic [15:0]        ctrl_q;
  logic [15:0]        ctrl_d;
  logic [15:0]        preset_reg_q;
  logic [15:0]        preset_reg_d;
  logic [15:0]        rdata_q;
  logic [15:0]        rdata_d;
  odt_pkg::odt_unit_e unit_sel;
  logic               preset_from_reg;
  logic [15:0]        preset_live;

  // Forward declarations for status reads
  logic        run_mem_q;
  logic        out_pin_q;
  logic        out_mem_q;
  logic [15:0] cur_q;

  assign unit_sel        = odt_pkg::odt_unit_e'(ctrl_q[`ODT_CTRL_UNIT_MSB:`ODT_CTRL_UNIT_LSB]);
  assign preset_from_reg = ctrl_q[`ODT_CTRL_SRC_BIT];
  assign preset_live     = preset_from_reg ? preset_reg_q : PRESET_CONST;

  always_comb begin
    ctrl_d       = ctrl_q;
    preset_reg_d = preset_reg_q;
    rdata_d      = `ODT_ZERO16;
    if (reg_wr) begin
      unique case (reg_addr)
        `ODT_ADDR_CTRL: begin
          ctrl_d = {13'h0000, reg_wdata[2:0]};
        end
        `ODT_ADDR_PRESET: begin
          preset_reg_d = reg_wdata;
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `ODT_ADDR_CTRL: begin
          rdata_d = ctrl_q;
        end
        `ODT_ADDR_PRESET: begin
          rdata_d = preset_reg_q;
        end
        `ODT_ADDR_CURRENT: begin
          rdata_d = cur_q;
        end
        `ODT_ADDR_FLAGS: begin
          rdata_d[`ODT_FLAG_OUT_MEM]                    = out_mem_q;
          rdata_d[`ODT_FLAG_OUT_PIN]                    = out_pin_q;
          rdata_d[`ODT_FLAG_RUN_MEM]                    = run_mem_q;
          rdata_d[`ODT_FLAG_IDX_OK]                     = IDX_OK;
          rdata_d[`ODT_FLAG_IDX_MSB:`ODT_FLAG_IDX_LSB] = IDX;
        end
        default: begin
          rdata_d = `ODT_ZERO16;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q       <= `ODT_CTRL_RST;
      preset_reg_q <= `ODT_PRESET_RST;
      rdata_q      <= `ODT_ZERO16;
    end else begin
      ctrl_q       <= ctrl_d;
      preset_reg_q <= preset_reg_d;
      rdata_q      <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------- Reference tick counter ----------------
  logic        sel_tick;
  logic [15:0] ref_q;
  logic [15:0] ref_d;

  always_comb begin
    unique case (unit_sel)
      odt_pkg::ODT_UNIT_1S:    sel_tick = tick_1s;
      odt_pkg::ODT_UNIT_100MS: sel_tick = tick_100ms;
      odt_pkg::ODT_UNIT_10MS:  sel_tick = tick_10ms;
      odt_pkg::ODT_UNIT_1MS:   sel_tick = tick_1ms;
    endcase
  end

  // Runs regardless of timer evaluation, so tick phase is unrelated to fb_exec
  always_comb begin
    ref_d = sel_tick ? ref_q + 16'h0001 : ref_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_q <= `ODT_ZERO16;
    end else begin
      ref_q <= ref_d;
    end
  end

  // ---------------- Input and output memory ----------------
  logic run_s1_q;
  logic run_s2_q;
  logic run_mem_d;
  logic out_pin_d;

  always_comb begin
    run_mem_d = scan_end ? run_s2_q : run_mem_q;
    out_pin_d = scan_end ? out_mem_q : out_pin_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_s1_q  <= 1'b0;
      run_s2_q  <= 1'b0;
      run_mem_q <= 1'b0;
      out_pin_q <= 1'b0;
    end else begin
      run_s1_q  <= run_input_pin;
      run_s2_q  <= run_s1_q;
      run_mem_q <= run_mem_d;
      out_pin_q <= out_pin_d;
    end
  end

  assign timer_out_pin = out_pin_q;

  // ---------------- Timer evaluation ----------------
  odt_pkg::odt_state_e state_q;
  odt_pkg::odt_state_e state_d;
  logic [15:0]         cur_d;
  logic [15:0]         last_ref_q;
  logic [15:0]         last_ref_d;
  logic                out_mem_d;
  logic [15:0]         delta;

  // Ticks since the last evaluation; wraps with the reference counter
  assign delta = ref_q - last_ref_q;

  always_comb begin
    state_d    = state_q;
    cur_d      = cur_q;
    last_ref_d = last_ref_q;
    if (fb_exec) begin
      last_ref_d = ref_q;
      unique case (state_q)
        odt_pkg::ODT_ST_IDLE: begin
          cur_d = preset_live;
          if (run_mem_q) begin
            if (preset_live == `ODT_ZERO16) begin
              state_d = odt_pkg::ODT_ST_EXPIRED;
            end else begin
              state_d = odt_pkg::ODT_ST_COUNT;
            end
          end
        end
        odt_pkg::ODT_ST_COUNT: begin
          if (!run_mem_q) begin
            state_d = odt_pkg::ODT_ST_IDLE;
            cur_d   = preset_live;
          end else if (preset_live == `ODT_ZERO16) begin
            state_d = odt_pkg::ODT_ST_EXPIRED;
            cur_d   = `ODT_ZERO16;
          end else if (delta >= cur_q) begin
            state_d = odt_pkg::ODT_ST_EXPIRED;
            cur_d   = `ODT_ZERO16;
          end else begin
            cur_d = cur_q - delta;
          end
        end
        odt_pkg::ODT_ST_EXPIRED: begin
          if (!run_mem_q) begin
            state_d = odt_pkg::ODT_ST_IDLE;
            cur_d   = preset_live;
          end else begin
            cur_d = `ODT_ZERO16;
          end
        end
        default: begin
          state_d = odt_pkg::ODT_ST_IDLE;
          cur_d   = preset_live;
        end
      endcase
    end
    // Output off whenever the timer is idle, else it tracks a zero value
    out_mem_d = (state_d != odt_pkg::ODT_ST_IDLE) && (cur_d == `ODT_ZERO16);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q    <= odt_pkg::ODT_ST_IDLE;
      cur_q      <= `ODT_ZERO16;
      last_ref_q <= `ODT_ZERO16;
      out_mem_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      cur_q      <= cur_d;
      last_ref_q <= last_ref_d;
      out_mem_q  <= out_mem_d;
    end
  end

  assign current_value = cur_q;

endmodule : odt_timer

// [logic/odt_cfg.svh]
// Purpose: Constants for the on-delay count-down timer
// Assumes: 125 MHz system clock
// Notes:   Offsets are word indices on the plain register port
`ifndef ODT_CFG_SVH
`define ODT_CFG_SVH

`define ODT_CLK_PERIOD_NS  8
`define ODT_TIME_1MS_NS    1000000
`define ODT_MS_CYCLES      (`ODT_TIME_1MS_NS / `ODT_CLK_PERIOD_NS)
`define ODT_DECADE         10

`define ODT_ADDR_CTRL      4'h0
`define ODT_ADDR_PRESET    4'h1
`define ODT_ADDR_CURRENT   4'h2
`define ODT_ADDR_FLAGS     4'h3

`define ODT_CTRL_UNIT_LSB  0
`define ODT_CTRL_UNIT_MSB  1
`define ODT_CTRL_SRC_BIT   2

`define ODT_FLAG_OUT_MEM   0
`define ODT_FLAG_OUT_PIN   1
`define ODT_FLAG_RUN_MEM   2
`define ODT_FLAG_IDX_OK    3
`define ODT_FLAG_IDX_LSB   8
`define ODT_FLAG_IDX_MSB   15

`define ODT_CTRL_RST       16'h0000
`define ODT_PRESET_RST     16'h0000
`define ODT_ZERO16         16'h0000

`define ODT_MAX_INDEX      199
`define ODT_MAX_INDEX_SML  99

`endif

// [logic/odt_pkg.sv]
// Purpose: Types for the on-delay count-down timer
// Assumes: Constants come from odt_cfg.svh
// Notes:   None
package odt_pkg;

  typedef enum logic [1:0] {
    ODT_UNIT_1S    = 2'b00,
    ODT_UNIT_100MS = 2'b01,
    ODT_UNIT_10MS  = 2'b10,
    ODT_UNIT_1MS   = 2'b11
  } odt_unit_e;

  typedef enum logic [1:0] {
    ODT_ST_IDLE    = 2'b00,
    ODT_ST_COUNT   = 2'b01,
    ODT_ST_EXPIRED = 2'b10
  } odt_state_e;

endpackage : odt_pkg

// [logic/odt_tick_div.sv]
// Purpose: Divide an input strobe into a one-cycle tick
// Assumes: step_in is a one-cycle strobe on clk
// Notes:   Tick is registered, one cycle after the last step
`timescale 1ns/10ps
module odt_tick_div #(
  parameter int unsigned   W   = 4,
  parameter logic [W-1:0]  DIV = W'(10)
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic step_in,
  output logic      tick_q
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_d;

  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (step_in) begin
      if (cnt_q == DIV - W'(1)) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule : odt_tick_div

// [verif/odt_props.sv]
// Purpose: Port-level checks for odt_timer
// Assumes: Scan end and execute strobes never fall on one edge
// Notes:   Bound to odt_timer after endmodule
`timescale 1ns/10ps
module odt_props (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        run_input_pin,
  input wire logic        scan_end,
  input wire logic        fb_exec,
  input wire logic        timer_out_pin,
  input wire logic [15:0] current_value,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr_pre;
    reg_wr && reg_addr == 4'h1;
  endsequence
  sequence s_rd_pre;
    reg_rd && reg_addr == 4'h1;
  endsequence
  property p_pin_scan;
    !$past(scan_end) |-> $stable(timer_out_pin);
  endproperty
  property p_cur_exec;
    !$past(fb_exec) |-> $stable(current_value);
  endproperty
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  property p_rd_cur;
    reg_rd && reg_addr == 4'h2 |=> reg_rdata == $past(current_value);
  endproperty
  property p_rd_ctrl;
    reg_rd && reg_addr == 4'h0 |=> reg_rdata[15:3] == 13'h0000;
  endproperty
  property p_rise_zero;
    $rose(timer_out_pin) |-> current_value == 16'h0000;
  endproperty
  property p_rst;
    $fell(sys_rst) |-> current_value == 16'h0000 && !timer_out_pin;
  endproperty
  property p_wr_rd;
    s_wr_pre ##1 s_rd_pre |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_pin_scan: assert property (p_pin_scan) else $error("pin moved off scan end");
  a_cur_exec: assert property (p_cur_exec) else $error("value moved off exec");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_rd_cur: assert property (p_rd_cur) else $error("current readback wrong");
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control upper bits set");
  a_rise_zero: assert property (p_rise_zero) else $error("output rose at nonzero");
  a_rst: assert property (p_rst) else $error("reset left state");
  a_wr_rd: assert property (p_wr_rd) else $error("preset readback wrong");
endmodule : odt_props

bind odt_timer odt_props u_props (
  .clk(clk), .sys_rst(sys_rst), .run_input_pin(run_input_pin),
  .scan_end(scan_end), .fb_exec(fb_exec), .timer_out_pin(timer_out_pin),
  .current_value(current_value), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// [verif/odt_scan_model.sv]
// Purpose: Host scan sequencer driving end-of-scan and execute strobes
// Assumes: Shares the timer clock
// Notes:   Slow mode stretches each scan to three times its length
`timescale 1ns/10ps
module odt_scan_model #(
  parameter int SCAN = 20
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic slow,
  output logic      scan_end,
  output logic      fb_exec
);
  int cnt_q;
  always_ff @(posedge clk) begin
    if (sys_rst || cnt_q >= (slow ? 3 * SCAN : SCAN) - 1) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  // Timer block runs mid-scan so the two strobes never meet
  assign scan_end = !sys_rst && cnt_q == 0;
  assign fb_exec  = !sys_rst && cnt_q == SCAN / 2;
endmodule : odt_scan_model

// [verif/tb_top.sv]
// Purpose: Self-checking bench for odt_timer
// Assumes: Millisecond shortened to 4 clocks, scan of 20 clocks
// Notes:   Every wait is bounded
`timescale 1ns/10ps
module tb_top;
  localparam int T  = 4;
  localparam int SC = 20;
  logic        clk = 0;
  logic        sys_rst = 1;
  logic        run_input_pin = 0;
  logic        slow = 0;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        scan_end, fb_exec, timer_out_pin;
  logic [15:0] current_value, reg_rdata, rv;
  int          error_cnt = 0;
  int          check_count = 0;
  int          n;
  int          tu[4] = '{4000, 400, 40, 4};
  always #4 clk = ~clk;
  odt_scan_model #(.SCAN(SC)) u_seq (.clk(clk), .sys_rst(sys_rst), .slow(slow),
    .scan_end(scan_end), .fb_exec(fb_exec));
  odt_timer #(.TICK_MS_CYCLES(T), .TIMER_INDEX(3), .PRESET_CONST(16'h0005)) dut (
    .clk(clk), .sys_rst(sys_rst), .run_input_pin(run_input_pin), .scan_end(scan_end),
    .fb_exec(fb_exec), .timer_out_pin(timer_out_pin), .current_value(current_value),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Read data stand in the cycle after the strobe; take them at the edge that closes it
    @(posedge clk);
    rv = reg_rdata;
  endtask : rd
  task automatic wait_pin(input logic lvl, input int lim);
    n = 0;
    while (timer_out_pin !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (timer_out_pin !== lvl) begin
      error_cnt++;
      $display("BAD timer_out_pin exp %b seen %b", lvl, timer_out_pin);
      wrap_up();
    end
  endtask : wait_pin
  task automatic t_reset();
    rd(4'h0); chk("ctrl", rv, 16'h0000);
    rd(4'h1); chk("preset", rv, 16'h0000);
    rd(4'h9); chk("unmapped", rv, 16'h0000);
    rd(4'h3); chk("index", {8'h00, rv[15:8]}, 16'h0003);
    chk("index ok", 16'(rv[3]), 16'h0001);
    repeat (2 * SC) @(posedge clk);
    chk("const preset", current_value, 16'h0005);
    wr(4'h2, 16'h1234);
    rd(4'h2); chk("cur ro", rv, 16'h0005);
    chk("pin off", 16'(timer_out_pin), 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_units();
    for (int u = 0; u < 4; u++) begin
      wr(4'h0, {13'h0000, 1'b1, 2'(u)});
      rd(4'h0); chk("unit", rv, {13'h0000, 1'b1, 2'(u)});
      wr(4'h1, 16'h0002);
      run_input_pin <= 1'b1;
      wait_pin(1'b1, 2 * tu[u] + 3 * SC + 8);
      chk("early", 16'(n >= tu[u]), 16'h0001);
      chk("zero", current_value, 16'h0000);
      repeat (2 * SC) @(posedge clk);
      chk("hold pin", 16'(timer_out_pin), 16'h0001);
      chk("hold zero", current_value, 16'h0000);
      run_input_pin <= 1'b0;
      wait_pin(1'b0, 2 * SC + 8);
      chk("reload", current_value, 16'h0002);
    end
    $display("test units done");
  endtask : t_units
  task automatic t_change();
    wr(4'h0, 16'hFFF7);
    rd(4'h0); chk("ctrl mask", rv, 16'h0007);
    wr(4'h1, 16'd20);
    rd(4'h1); chk("preset rb", rv, 16'd20);
    run_input_pin <= 1'b1;
    repeat (40) @(posedge clk);
    wr(4'h1, 16'd50);
    wait_pin(1'b1, 110);
    run_input_pin <= 1'b0;
    wait_pin(1'b0, 2 * SC + 8);
    chk("new preset", current_value, 16'd50);
    run_input_pin <= 1'b1;
    repeat (3 * SC) @(posedge clk);
    chk("still counting", 16'(timer_out_pin), 16'h0000);
    chk("decrement", 16'(current_value < 16'd50), 16'h0001);
    wr(4'h1, 16'h0000);
    wait_pin(1'b1, 2 * SC + 8);
    run_input_pin <= 1'b0;
    wait_pin(1'b0, 2 * SC + 8);
    $display("test change done");
  endtask : t_change
  task automatic t_rst_mid();
    slow <= 1'b1;
    wr(4'h1, 16'd50);
    run_input_pin <= 1'b1;
    repeat (8 * SC) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("rst cur", current_value, 16'h0000);
    chk("rst pin", 16'(timer_out_pin), 16'h0000);
    run_input_pin <= 1'b0;
    slow <= 1'b0;
    repeat (2 * SC) @(posedge clk);
    chk("restart", current_value, 16'h0005);
    rd(4'h0); chk("rst ctrl", rv, 16'h0000);
    $display("test mid reset done");
  endtask : t_rst_mid
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_units();
    t_change();
    t_rst_mid();
    wrap_up();
  end
endmodule : tb_top
